// ==== hw/psp_ctrl.v ====
/*
 * Three-stage power-stage PWM configuration and control with a simple
 * one-counter waveform engine per stage, Wishbone classic slave, 8-bit
 * data in the low lane of a 32-bit bus.
 * Assumes clk_i at 20 MHz; counter clocks and fault lines are pins from
 * outside the clock domain and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "psp_defs.vh"

module psp_ctrl (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // counter clock pins
    input wire fast_clock_input_i,
    input wire slow_clock_input_i,
    // fault inputs per stage
    input wire [2:0] fault_a_i,
    input wire [2:0] fault_b_i,
    // waveform outputs per stage
    output reg [2:0] part_a_output_o,
    output reg [2:0] part_b_output_o,
    output reg [2:0] part_a_enable_o,
    output reg [2:0] part_b_enable_o,
    output reg [2:0] stage_running_o,
    // interrupt
    output wire irq_o
);

// ------------------------------------------------------------
// functions
// ------------------------------------------------------------
function [7:0] div_last;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: div_last = `PSP_DIV_1;
            2'h1: div_last = `PSP_DIV_4;
            2'h2: div_last = `PSP_DIV_32;
            default: div_last = `PSP_DIV_256;
        endcase
    end
endfunction

// ------------------------------------------------------------
// storage
// ------------------------------------------------------------
reg [7:0] stage_configuration [0:2];
reg [7:0] stage_run_control [0:2];
reg [7:0] ocfg_buf [0:2];
reg [7:0] output_configuration [0:2];
reg [3:0] mtx_buf;
reg [3:0] output_matrix;
reg [11:0] ra_buf [0:2];
reg [11:0] sa_buf [0:2];
reg [11:0] sb_buf [0:2];
reg [15:0] rb_buf [0:2];
reg [11:0] part_a_reset_compare [0:2];
reg [11:0] part_a_set_compare [0:2];
reg [11:0] part_b_set_compare [0:2];
reg [15:0] part_b_reset_compare [0:2];
reg [2:0] rb_last;
reg [7:0] temp_high;
reg [11:0] cnt [0:2];
reg [2:0] down;
reg [7:0] pre [0:2];
reg [3:0] fwm_cyc [0:2];
reg [2:0] wave_a;
reg [2:0] wave_b;
reg [2:0] stop_pend;
reg [2:0] irq_status;
reg [2:0] irq_enable;
reg [7:0] sync1;
reg [7:0] sync2;
reg [1:0] clk_prev;
integer s;
integer r;
integer c;

// ------------------------------------------------------------
// bus decode
// ------------------------------------------------------------
wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wr = bus_req & wb_we_i & wb_sel_i[0];
wire [1:0] wstage = wb_adr_i[7:6];
wire [5:0] wofs = wb_adr_i[5:0];
wire stage_hit = (wstage != 2'h3);
wire [7:0] d = wb_dat_i[7:0];
wire irq_clr_wr = wr & (wb_adr_i == `PSP_OFS_IRQ_CLR);

assign irq_o = |(irq_status & irq_enable);

// ------------------------------------------------------------
// synchronisers: stage 1 feeds stage 2 only
// ------------------------------------------------------------
always @(posedge clk_i) begin
    if (rst_i) begin
        sync1 <= `PSP_RST_BYTE;
        sync2 <= `PSP_RST_BYTE;
        clk_prev <= 2'h0;
    end else begin
        sync1 <= {fast_clock_input_i, slow_clock_input_i, fault_b_i, fault_a_i};
        sync2 <= sync1;
        clk_prev <= sync2[7:6];
    end
end

wire fast_rise = sync2[7] & ~clk_prev[1];
wire slow_rise = sync2[6] & ~clk_prev[0];
wire [2:0] flt_a = sync2[2:0];
wire [2:0] flt_b = sync2[5:3];

// ------------------------------------------------------------
// run / autostart chain
// ------------------------------------------------------------
wire [2:0] run_bit;
wire [2:0] arun_bit;
wire [2:0] start;
assign run_bit = {stage_run_control[2][`PSP_CTL_RUN], stage_run_control[1][`PSP_CTL_RUN],
                  stage_run_control[0][`PSP_CTL_RUN]};
assign arun_bit = {stage_run_control[2][`PSP_CTL_ARUN], stage_run_control[1][`PSP_CTL_ARUN],
                   stage_run_control[0][`PSP_CTL_ARUN]};
// run bit wins; autostart follows the chained source
assign start[0] = run_bit[0] | (arun_bit[0] & (run_bit[2] | (arun_bit[2] & run_bit[1])));
assign start[1] = run_bit[1] | (arun_bit[1] & (run_bit[0] | (arun_bit[0] & run_bit[2])));
assign start[2] = run_bit[2] | (arun_bit[2] & (run_bit[1] | (arun_bit[1] & run_bit[0])));

// ------------------------------------------------------------
// register writes and reads
// ------------------------------------------------------------
always @(posedge clk_i) begin
    if (rst_i) begin
        for (r = 0; r < 3; r = r + 1) begin
            stage_configuration[r] <= `PSP_RST_BYTE;
            stage_run_control[r] <= `PSP_RST_BYTE;
            ocfg_buf[r] <= `PSP_RST_BYTE;
            ra_buf[r] <= `PSP_RST_CMP12;
            sa_buf[r] <= `PSP_RST_CMP12;
            sb_buf[r] <= `PSP_RST_CMP12;
            rb_buf[r] <= `PSP_RST_CMP16;
        end
        mtx_buf <= 4'h0;
        rb_last <= 3'h0;
        temp_high <= `PSP_RST_BYTE;
        irq_enable <= 3'h0;
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= bus_req;
        wb_dat_o <= 32'h00000000;
        if (bus_req & ~wb_we_i) begin
            if (stage_hit && wofs == `PSP_OFS_CNF)
                wb_dat_o <= {24'h000000, stage_configuration[wstage]};
            else if (stage_hit && wofs == `PSP_OFS_CTL)
                wb_dat_o <= {24'h000000, stage_run_control[wstage]};
            else if (stage_hit && wofs == `PSP_OFS_OCFG)
                wb_dat_o <= {24'h000000, ocfg_buf[wstage]};
            else if (wstage == 2'h2 && wofs == `PSP_OFS_MTX)
                wb_dat_o <= {28'h0000000, mtx_buf};
            else if (wb_adr_i == `PSP_OFS_IRQ_STAT)
                wb_dat_o <= {29'h00000000, irq_status};
            else if (wb_adr_i == `PSP_OFS_IRQ_EN)
                wb_dat_o <= {29'h00000000, irq_enable};
        end
        if (wr && wb_adr_i == `PSP_OFS_IRQ_EN)
            irq_enable <= d[2:0];
        if (wr && stage_hit) begin
            case (wofs)
                `PSP_OFS_CNF: begin
                    stage_configuration[wstage] <= d;
                end
                `PSP_OFS_CTL: begin
                    stage_run_control[wstage] <= d;
                end
                `PSP_OFS_OCFG: begin
                    ocfg_buf[wstage] <= d;
                end
                `PSP_OFS_MTX: begin
                    if (wstage == 2'h2)
                        mtx_buf <= d[3:0];
                end
                `PSP_OFS_SAH, `PSP_OFS_RAH, `PSP_OFS_SBH, `PSP_OFS_RBH: begin
                    temp_high <= d;
                end
                `PSP_OFS_SAL: begin
                    sa_buf[wstage] <= {temp_high[3:0], d};
                    rb_last[wstage] <= 1'b0;
                end
                `PSP_OFS_RAL: begin
                    ra_buf[wstage] <= {temp_high[3:0], d};
                    rb_last[wstage] <= 1'b0;
                end
                `PSP_OFS_SBL: begin
                    sb_buf[wstage] <= {temp_high[3:0], d};
                    rb_last[wstage] <= 1'b0;
                end
                `PSP_OFS_RBL: begin
                    rb_buf[wstage] <= {temp_high, d};
                    rb_last[wstage] <= 1'b1;
                    if (stage_configuration[wstage][`PSP_CNF_HALF]) begin
                        ra_buf[wstage] <= {temp_high[3:0], d};
                        sa_buf[wstage] <= sb_buf[wstage];
                    end
                end
                default: begin
                end
            endcase
        end
    end
end

// ------------------------------------------------------------
// stage engines
// ------------------------------------------------------------
// the modulation nibble stretches on-time by one tick in that many of
// every sixteen cycles; coarse, but keeps the average resolution
reg [2:0] tick;
reg [2:0] eoc;
reg [2:0] ext;
reg [2:0] hold_all;
reg [2:0] mtx_on;
always @* begin
    for (c = 0; c < 3; c = c + 1) begin
        tick[c] = stage_running_o[c] &
                  (stage_configuration[c][`PSP_CNF_CLKSEL] ? fast_rise : slow_rise) &
                  (pre[c] == div_last(stage_run_control[c][7:6]));
        if (stage_configuration[c][4:3] == `PSP_MODE_CENTER)
            eoc[c] = tick[c] & down[c] & (cnt[c] == 12'h000);
        else
            eoc[c] = tick[c] & (cnt[c] == part_b_reset_compare[c][11:0]);
        ext[c] = (fwm_cyc[c] < part_b_reset_compare[c][15:12]);
        // auto hold wins over plain hold
        hold_all[c] = stage_configuration[c][`PSP_CNF_HOLD] &
                      ~stage_configuration[c][`PSP_CNF_AHOLD];
        mtx_on[c] = (c == 2) & stage_configuration[c][`PSP_CNF_MTXEN];
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        for (s = 0; s < 3; s = s + 1) begin
            output_configuration[s] <= `PSP_RST_BYTE;
            part_a_reset_compare[s] <= `PSP_RST_CMP12;
            part_a_set_compare[s] <= `PSP_RST_CMP12;
            part_b_set_compare[s] <= `PSP_RST_CMP12;
            part_b_reset_compare[s] <= `PSP_RST_CMP16;
            cnt[s] <= `PSP_RST_CMP12;
            pre[s] <= `PSP_RST_BYTE;
            fwm_cyc[s] <= 4'h0;
        end
        output_matrix <= 4'h0;
        down <= 3'h0;
        wave_a <= 3'h0;
        wave_b <= 3'h0;
        stop_pend <= 3'h0;
        irq_status <= 3'h0;
        stage_running_o <= 3'h0;
        part_a_output_o <= 3'h0;
        part_b_output_o <= 3'h0;
        part_a_enable_o <= 3'h0;
        part_b_enable_o <= 3'h0;
    end else begin
        // end-of-cycle events are sticky; a set beats a clear
        irq_status <= (irq_status & ~(irq_clr_wr ? d[2:0] : 3'h0)) | eoc;
        for (s = 0; s < 3; s = s + 1) begin
            // shadow to active transfer
            if (~hold_all[s])
                part_b_reset_compare[s] <= rb_buf[s];
            if (stage_configuration[s][`PSP_CNF_AHOLD]) begin
                if (eoc[s] & rb_last[s]) begin
                    part_a_reset_compare[s] <= ra_buf[s];
                    part_a_set_compare[s] <= sa_buf[s];
                    part_b_set_compare[s] <= sb_buf[s];
                    output_configuration[s] <= ocfg_buf[s];
                    if (s == 2)
                        output_matrix <= mtx_buf;
                end
            end else if (~stage_configuration[s][`PSP_CNF_HOLD]) begin
                part_a_reset_compare[s] <= ra_buf[s];
                part_a_set_compare[s] <= sa_buf[s];
                part_b_set_compare[s] <= sb_buf[s];
                output_configuration[s] <= ocfg_buf[s];
                if (s == 2)
                    output_matrix <= mtx_buf;
            end

            // run state; finishing the cycle only applies to a master
            if (start[s]) begin
                stage_running_o[s] <= 1'b1;
                stop_pend[s] <= 1'b0;
            end else if (stage_running_o[s]) begin
                // a stop once pending still waits for the cycle end
                if ((stage_run_control[s][`PSP_CTL_CCYC] | stop_pend[s]) &
                    ~arun_bit[s] & ~eoc[s])
                    stop_pend[s] <= 1'b1;
                else begin
                    stage_running_o[s] <= 1'b0;
                    stop_pend[s] <= 1'b0;
                end
            end

            // prescaler and counter
            if (~stage_running_o[s]) begin
                pre[s] <= `PSP_RST_BYTE;
                cnt[s] <= `PSP_RST_CMP12;
                down[s] <= 1'b0;
                wave_a[s] <= 1'b0;
                wave_b[s] <= 1'b0;
            end else if ((stage_configuration[s][`PSP_CNF_CLKSEL] ? fast_rise : slow_rise)) begin
                if (tick[s])
                    pre[s] <= `PSP_RST_BYTE;
                else
                    pre[s] <= pre[s] + 8'h01;
            end
            if (tick[s]) begin
                if (stage_configuration[s][4:3] == `PSP_MODE_CENTER) begin
                    if (~down[s] & (cnt[s] == part_b_reset_compare[s][11:0]))
                        down[s] <= 1'b1;
                    else if (down[s] & (cnt[s] == 12'h000))
                        down[s] <= 1'b0;
                    cnt[s] <= (down[s] & (cnt[s] != 12'h000)) ? cnt[s] - 12'h001
                              : (~down[s] & (cnt[s] != part_b_reset_compare[s][11:0]))
                              ? cnt[s] + 12'h001 : cnt[s];
                end else begin
                    cnt[s] <= eoc[s] ? 12'h000 : cnt[s] + 12'h001;
                end
                if (eoc[s])
                    fwm_cyc[s] <= fwm_cyc[s] + 4'h1;
                // compare matches drive the raw waveforms
                if (cnt[s] == part_a_set_compare[s])
                    wave_a[s] <= 1'b1;
                else if (cnt[s] == part_a_reset_compare[s] +
                         {11'h000, ext[s] & stage_run_control[s][`PSP_CTL_BAL]})
                    wave_a[s] <= 1'b0;
                if (cnt[s] == part_b_set_compare[s])
                    wave_b[s] <= 1'b1;
                else if (cnt[s] == part_b_reset_compare[s][11:0] + {11'h000, ext[s]})
                    wave_b[s] <= 1'b0;
            end

            // output stage: a fault forces inactive only when its AOCA/AOCB bit is set, matrix bypasses polarity and fault
            part_a_enable_o[s] <= output_configuration[s][`PSP_OCFG_ENA];
            part_b_enable_o[s] <= output_configuration[s][`PSP_OCFG_ENB];
            if (mtx_on[s]) begin
                part_a_output_o[s] <= wave_a[s] ? output_matrix[0] : output_matrix[1];
                part_b_output_o[s] <= wave_b[s] ? output_matrix[2] : output_matrix[3];
            end else begin
                part_a_output_o[s] <= ~(wave_a[s] & ~(stage_run_control[s][`PSP_CTL_AOCA] &
                                      flt_a[s])) ^ stage_configuration[s][`PSP_CNF_POL];
                part_b_output_o[s] <= ~(wave_b[s] & ~(stage_run_control[s][`PSP_CTL_AOCB] &
                                      flt_b[s])) ^ stage_configuration[s][`PSP_CNF_POL];
            end
        end
    end
end

endmodule // psp_ctrl
`default_nettype wire

// ==== hw/psp_defs.vh ====
/*
 * Constants of the power-stage PWM configuration and control block:
 * register offsets, field positions, reset values and divider counts.
 * Assumes a Wishbone byte address; each register is one aligned word.
 */
`ifndef PSP_DEFS_VH
`define PSP_DEFS_VH

// ------------------------------------------------------------
// register offsets inside a stage window (stage base = stage * 0x40)
// ------------------------------------------------------------
`define PSP_STAGE_STRIDE 8'h40
`define PSP_OFS_CNF 6'h00
`define PSP_OFS_CTL 6'h04
`define PSP_OFS_OCFG 6'h08
`define PSP_OFS_MTX 6'h0C
`define PSP_OFS_SAH 6'h10
`define PSP_OFS_SAL 6'h14
`define PSP_OFS_RAH 6'h18
`define PSP_OFS_RAL 6'h1C
`define PSP_OFS_SBH 6'h20
`define PSP_OFS_SBL 6'h24
`define PSP_OFS_RBH 6'h28
`define PSP_OFS_RBL 6'h2C
// global interrupt registers
`define PSP_OFS_IRQ_STAT 8'hC0
`define PSP_OFS_IRQ_EN 8'hC4
`define PSP_OFS_IRQ_CLR 8'hC8

// ------------------------------------------------------------
// configuration fields
// ------------------------------------------------------------
`define PSP_CNF_HALF 7
`define PSP_CNF_AHOLD 6
`define PSP_CNF_HOLD 5
`define PSP_CNF_MODE_HI 4
`define PSP_CNF_MODE_LO 3
`define PSP_CNF_POL 2
`define PSP_CNF_CLKSEL 1
`define PSP_CNF_MTXEN 0
`define PSP_MODE_CENTER 2'h3

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define PSP_CTL_DIV_HI 7
`define PSP_CTL_DIV_LO 6
`define PSP_CTL_BAL 5
`define PSP_CTL_AOCB 4
`define PSP_CTL_AOCA 3
`define PSP_CTL_ARUN 2
`define PSP_CTL_CCYC 1
`define PSP_CTL_RUN 0

// output configuration enables
`define PSP_OCFG_ENB 2
`define PSP_OCFG_ENA 0

// ------------------------------------------------------------
// reset values and divider terminal counts (ratio - 1)
// ------------------------------------------------------------
`define PSP_RST_BYTE 8'h00
`define PSP_RST_CMP12 12'h000
`define PSP_RST_CMP16 16'h0000
`define PSP_DIV_1 8'h00
`define PSP_DIV_4 8'h03
`define PSP_DIV_32 8'h1F
`define PSP_DIV_256 8'hFF

`endif

// ==== verification/psp_ctrl_monitor.sv ====
/* checker of psp_ctrl: bus handshake, write-only reads, run starts
   sees only the top ports; bound at the foot of this file */
`timescale 1ns/1ps
`default_nettype none
module psp_ctrl_chk (
    // clock, reset and bus
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // stage outputs
    input wire [2:0] part_a_output_o,
    input wire [2:0] part_b_output_o,
    input wire [2:0] stage_running_o,
    input wire irq_o
);
    // ----
    // shadow of run bits, so start relations can be tied to writes
    // ----
    logic [2:0] sh_run;
    logic sh_arun0;
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire ctl_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i[5:0] == 6'h04;
    always @(posedge clk_i) begin
        if (rst_i) begin
            sh_run <= 3'h0;
            sh_arun0 <= 1'b0;
        end else if (ctl_wr && wb_adr_i[7:6] != 2'h3) begin
            sh_run[wb_adr_i[7:6]] <= wb_dat_i[0];
            if (wb_adr_i[7:6] == 2'h0)
                sh_arun0 <= wb_dat_i[2];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_follows_take_a: assert property (take |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_has_cause_a: assert property (wb_ack_o |-> $past(take))
        else $error("ack without a request");
    read_upper_zero_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper lanes not zero");
    compare_reads_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[5:4] != 2'h0
        && wb_adr_i[7:6] != 2'h3 |-> wb_dat_o == 32'h0)
        else $error("write-only compare read back non-zero");
    idle_levels_equal_a: assert property (!stage_running_o[0] [*3]
        |-> part_a_output_o[0] == part_b_output_o[0])
        else $error("stopped stage parts at different levels");
    run_bit_start_a: assert property ($rose(sh_run[0]) |-> ##[1:4] stage_running_o[0])
        else $error("run bit did not start stage");
    chained_start_a: assert property ($rose(sh_run[2]) && sh_arun0
        |-> ##[1:4] stage_running_o[0])
        else $error("first stage did not follow third");
    cover property (take && wb_we_i);
    cover property (stage_running_o[0] && irq_o);
    cover property ($rose(stage_running_o[2]));
endmodule // psp_ctrl_chk

bind psp_ctrl psp_ctrl_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .part_a_output_o, .part_b_output_o,
    .stage_running_o, .irq_o);
`default_nettype wire

// ==== verification/psp_switch_model.sv ====
/* power switch model: counts switch-on events of stage 0, drives faults
   assumes active-high outputs while counting (polarity set) */
`timescale 1ns/1ps
`default_nettype none
module psp_switch_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // waveform pins and fault request
    input wire logic [2:0] part_a_output_i,
    input wire logic [2:0] part_b_output_i,
    input wire logic [2:0] fault_req_i,
    // fault lines and switch-on counts
    output logic [2:0] fault_a_o,
    output logic [2:0] fault_b_o,
    output logic [15:0] on_a_o,
    output logic [15:0] on_b_o
);
    logic pa_q;
    logic pb_q;
    // a fault trips both halves of the bridge together
    assign fault_a_o = fault_req_i;
    assign fault_b_o = fault_req_i;
    always @(posedge clk_i) begin
        pa_q <= part_a_output_i[0];
        pb_q <= part_b_output_i[0];
        if (rst_i) begin
            on_a_o <= 16'h0000;
            on_b_o <= 16'h0000;
        end else begin
            on_a_o <= on_a_o + {15'h0000, part_a_output_i[0] & ~pa_q};
            on_b_o <= on_b_o + {15'h0000, part_b_output_i[0] & ~pb_q};
        end
    end
endmodule // psp_switch_model
`default_nettype wire

// ==== verification/tb_power_stage_pwm_config_ctrl.sv ====
/* self-checking bench of psp_ctrl over classic wishbone
   assumes the design, its defines header and the switch model are compiled */
`timescale 1ns/1ps
`default_nettype none
`include "psp_defs.vh"
module tb_power_stage_pwm_config_ctrl;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic fpin = 1'b0, spin = 1'b0, ack, irq;
    logic [1:0] pc = 2'h0;
    logic [7:0] adr = 8'h00, v;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [31:0] expq [$];
    logic [2:0] fa, fb, pa, pb, ena, enb, run, freq = 3'h0;
    logic [15:0] on_a, on_b, na, nb;
    integer bad_count = 0, cmp_count = 0, seed = 50, i;
    psp_ctrl dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .fast_clock_input_i(fpin), .slow_clock_input_i(spin), .fault_a_i(fa), .fault_b_i(fb),
        .part_a_output_o(pa), .part_b_output_o(pb), .part_a_enable_o(ena),
        .part_b_enable_o(enb), .stage_running_o(run), .irq_o(irq));
    psp_switch_model sw_u (.clk_i, .rst_i, .part_a_output_i(pa), .part_b_output_i(pb),
        .fault_req_i(freq), .fault_a_o(fa), .fault_b_o(fb), .on_a_o(on_a), .on_b_o(on_b));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // counter clock pins: fast every 2 clocks, slow every 8
    always @(posedge clk_i) begin
        fpin <= ~fpin;
        pc <= pc + 2'h1;
        if (pc == 2'h3)
            spin <= ~spin;
    end
    // ----
    // report and bus tasks
    // ----
    task automatic end_sim;
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bad(input string m);
        bad_count = bad_count + 1;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic chk(input logic c, input string m);
        cmp_count = cmp_count + 1;
        if (c !== 1'b1)
            bad(m);
    endtask
    task automatic tick(input integer c);
        repeat (c) @(posedge clk_i);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        integer k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= {24'h0, d};
        for (k = 0; k < 20 && ack !== 1'b1; k = k + 1)
            @(posedge clk_i);
        if (ack !== 1'b1) begin
            bad("bus timeout");
            end_sim;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back({24'h0, e});
        xfer(1'b0, a, 8'h00);
    endtask
    task automatic wr16(input logic [1:0] s, input logic [5:0] h, input logic [15:0] d);
        xfer(1'b1, {s, h}, d[15:8]);
        xfer(1'b1, {s, h + 6'h04}, d[7:0]);
    endtask
    task automatic wait_run(input integer s, input logic lv);
        integer k;
        for (k = 0; k < 400 && run[s] !== lv; k = k + 1)
            @(posedge clk_i);
        if (run[s] !== lv) begin
            bad("stage run state timeout");
            end_sim;
        end
    endtask
    // read results are taken at the ack edge, oldest note first
    always @(posedge clk_i) begin
        if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
            cmp_count = cmp_count + 1;
            if (expq.size() == 0)
                bad("read data without a note");
            else if (rdat !== expq.pop_front())
                bad("read data mismatch");
        end
    end
    // ----
    // main sequence
    // ----
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        tick(3);
        chk(pa[0] === 1'b1 && pb[0] === 1'b1, "idle level with polarity clear");
        for (i = 0; i < 3; i = i + 1) begin
            rd({i[1:0], `PSP_OFS_CNF}, 8'h00);
            rd({i[1:0], `PSP_OFS_CTL}, 8'h00);
            rd({i[1:0], `PSP_OFS_SAL}, 8'h00);
            rd({i[1:0], `PSP_OFS_RBH}, 8'h00);
        end
        rd(8'hF0, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            v = 8'($random(seed));
            v[4:3] = i[1:0];
            xfer(1'b1, {2'h1, `PSP_OFS_CNF}, v);
            rd({2'h1, `PSP_OFS_CNF}, v);
            xfer(1'b1, {2'h1, `PSP_OFS_CTL}, {i[1:0], 6'h00});
            rd({2'h1, `PSP_OFS_CTL}, {i[1:0], 6'h00});
        end
        xfer(1'b1, {2'h1, `PSP_OFS_CNF}, 8'h00);
        wr16(2'h0, `PSP_OFS_SAH, 16'h0001);
        wr16(2'h0, `PSP_OFS_RAH, 16'h0005);
        wr16(2'h0, `PSP_OFS_SBH, 16'h0002);
        wr16(2'h0, `PSP_OFS_RBH, 16'h0008);
        xfer(1'b1, {2'h0, `PSP_OFS_CNF}, 8'h06);
        xfer(1'b1, {2'h0, `PSP_OFS_OCFG}, 8'h05);
        xfer(1'b1, {2'h0, `PSP_OFS_CTL}, 8'h01);
        wait_run(0, 1'b1);
        tick(100);
        chk(on_a > 16'h0 && on_b > 16'h0, "stage 0 never switched");
        chk(ena[0] === 1'b1 && enb[0] === 1'b1, "output enables not set");
        xfer(1'b1, `PSP_OFS_IRQ_EN, 8'h01);
        tick(1);
        chk(irq === 1'b1, "end of cycle interrupt missing");
        xfer(1'b1, `PSP_OFS_IRQ_EN, 8'h00);
        tick(1);
        chk(irq === 1'b0, "masked interrupt still high");
        xfer(1'b1, {2'h0, `PSP_OFS_CTL}, 8'h03);
        // stop right after an end of cycle, so the stop has to wait for the next one
        xfer(1'b1, `PSP_OFS_IRQ_EN, 8'h01);
        xfer(1'b1, `PSP_OFS_IRQ_CLR, 8'h01);
        for (i = 0; i < 40 && irq !== 1'b1; i = i + 1)
            tick(1);
        chk(irq === 1'b1, "no end of cycle seen");
        xfer(1'b1, {2'h0, `PSP_OFS_CTL}, 8'h02);
        tick(1);
        chk(run[0] === 1'b1, "stopped before cycle end");
        wait_run(0, 1'b0);
        tick(3);
        chk(pa[0] === 1'b0 && pb[0] === 1'b0, "idle level with polarity set");
        rd(`PSP_OFS_IRQ_STAT, 8'h01);
        xfer(1'b1, `PSP_OFS_IRQ_EN, 8'h01);
        tick(1);
        chk(irq === 1'b1, "sticky status lost");
        xfer(1'b1, `PSP_OFS_IRQ_CLR, 8'h01);
        tick(1);
        chk(irq === 1'b0, "interrupt not cleared");
        rd(`PSP_OFS_IRQ_STAT, 8'h00);
        xfer(1'b1, {2'h1, `PSP_OFS_CTL}, 8'h04);
        xfer(1'b1, {2'h0, `PSP_OFS_CTL}, 8'h04);
        tick(6);
        chk(run === 3'h0, "autorun started alone");
        xfer(1'b1, {2'h2, `PSP_OFS_CTL}, 8'h01);
        wait_run(0, 1'b1);
        wait_run(1, 1'b1);
        for (i = 0; i < 3; i = i + 1)
            xfer(1'b1, {i[1:0], `PSP_OFS_CTL}, 8'h00);
        xfer(1'b1, {2'h0, `PSP_OFS_CTL}, 8'h11);
        wait_run(0, 1'b1);
        freq <= 3'h1;
        tick(8);
        na = on_a;
        nb = on_b;
        tick(60);
        chk(on_b === nb && pb[0] === 1'b0, "fault did not hold part b off");
        chk(on_a > na, "part a stopped without its fault control");
        freq <= 3'h0;
        xfer(1'b1, {2'h0, `PSP_OFS_CNF}, 8'h86);
        wr16(2'h0, `PSP_OFS_SBH, 16'h0003);
        wr16(2'h0, `PSP_OFS_RBH, 16'h0009);
        tick(40);
        for (i = 0; i < 40; i = i + 1) begin
            chk(pa[0] === pb[0], "half duty parts differ");
            tick(1);
        end
        end_sim;
    end
endmodule // tb_power_stage_pwm_config_ctrl
`default_nettype wire
